// ---- sup_pkg.sv ----
package sup_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int SEC_TIME_MS   = 1000;
  localparam int SEC_CYCLES    = SEC_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int BLINK_HALF_MS = 250;
  localparam int BLINK_CYCLES  = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;
  localparam int RST_HOLD_US   = 100;
  localparam int RST_HOLD_CYC  = RST_HOLD_US * 1000 / CLK_PERIOD_NS;
  localparam int SETTLE_CYCLES = 3;
  localparam logic [2:0] OVR_SEC = 3'h4;

  // Selectable watchdog periods, in seconds.
  localparam logic [7:0] PERIOD_SEC_0 = 8'h02;
  localparam logic [7:0] PERIOD_SEC_1 = 8'h0a;
  localparam logic [7:0] PERIOD_SEC_2 = 8'h32;
  localparam logic [7:0] PERIOD_SEC_3 = 8'hff;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_STATUS  = 4'h4;
  localparam int CTRL_PER_LSB = 0;
  localparam int CTRL_SWFAIL  = 2;
  localparam int CTRL_RSTDIS  = 3;
  localparam int CTRL_PWRDIS  = 4;
  localparam int CTRL_GPGREEN = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [9:0] SYNC_RESET = 10'h300;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic red;
    logic green;
  } led_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef enum logic [1:0] {
    SLP_S0 = 2'h0,
    SLP_S3 = 2'h1,
    SLP_S4 = 2'h2,
    SLP_S5 = 2'h3
  } sleep_t;

  typedef enum logic [4:0] {
    HS_INIT       = 5'h01,
    HS_RUN        = 5'h02,
    HS_OFF_OPEN   = 5'h04,
    HS_OFF_LOCKED = 5'h08,
    HS_OFF_REOPEN = 5'h10
  } handle_state_t;

endpackage

// ---- pin_sync.sv ----
module pin_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_sys,  // system clock
  input  wire logic         rstn,     // synchronous reset, active low
  input  wire logic [W-1:0] d,        // asynchronous pins
  output logic      [W-1:0] q         // synchronised pins
);

  logic [W-1:0] meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      meta_q <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

// ---- tick_div.sv ----
module tick_div #(
  parameter int PERIOD = 4
) (
  input  wire logic clk_sys,  // system clock
  input  wire logic rstn,     // synchronous reset, active low
  input  wire logic clr,      // restart the period from zero
  output logic      tick      // one-cycle pulse per period
);

  localparam int W = (PERIOD > 1) ? $clog2(PERIOD) : 1;

  logic [W-1:0] cnt_q;

  always_ff @(posedge clk_sys) begin
    if (!rstn || clr) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else if (cnt_q == W'(PERIOD - 1)) begin
      cnt_q <= '0;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      tick  <= 1'b0;
    end
  end

  a_tick_single: assert property (@(posedge clk_sys) disable iff (!rstn)
    tick |=> !tick) else $error("tick longer than one cycle");

endmodule

// ---- board_supervisor_watchdog.sv ----
// Contract
// - Timeout selectable: 2, 10, 50, 255 s.
// - Idle after reset until first trigger.
// - First trigger arms and starts timing.
// - Late trigger when armed forces board reset.
// - Armed stays armed until next reset.
// - Period writable at any time.
// - Each button press gives one event pulse.
// - Handle open 4 s forces soft-off.
// - Unlock then lock returns to working.
// - Open handle at power-up means soft-off.
// - External reset equals reset button.
// - Button and handle power function disableable.
// - Power indicator steady green only with rails good, reset released.
// - Sleep state indicator patterns.
// - Healthy working board shows steady green.
// - Open handle blinks power indicator yellow.
// - Power fault shows steady red.
// - Software failure flag blinks red.
module board_supervisor_watchdog #(
  parameter int SEC_CYCLES    = sup_pkg::SEC_CYCLES,
  parameter int BLINK_CYCLES  = sup_pkg::BLINK_CYCLES,
  parameter int RST_HOLD_CYC  = sup_pkg::RST_HOLD_CYC
) (
  input  wire logic             clk_sys,                 // system clock, 50 MHz
  input  wire logic             rstn,                    // synchronous reset, active low
  input  wire sup_pkg::reg_req_t reg_req,                // register request
  output logic [7:0]            rdata,                   // read data, cycle after read
  input  wire logic             reset_button_n,          // front reset button, low pressed
  input  wire logic             ext_reset_in_n,          // external reset, low active
  input  wire logic             handle_unlocked,         // front handle open
  input  wire logic             handle_button,           // handle release button pressed
  input  wire logic             rails_ok,                // all supply rails in limits
  input  wire logic             power_fault,             // hardware power fault
  input  wire logic [1:0]       sleep_state,             // chipset sleep state
  input  wire logic             disk_act_sata,           // disk activity, green lane
  input  wire logic             disk_act_raid,           // disk activity, yellow lane
  output logic                  board_reset_n,           // board reset, active low
  output logic                  pwr_btn_event,           // power button event pulse
  output logic                  pwr_btn_override,        // override pulse
  output logic                  soft_off,                // soft-off request level
  output sup_pkg::led_t         power_good_indicator,    // red and green
  output sup_pkg::led_t         general_indicator,       // red and green
  output sup_pkg::led_t         disk_activity_indicator  // red lane drives yellow
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic       btn_n_s;
  logic       ext_n_s;
  logic       unlocked_s;
  logic       hbtn_s;
  logic       rails_s;
  logic       fault_s;
  logic [1:0] sleep_s;
  logic       sata_s;
  logic       raid_s;

  pin_sync #(
    .W       (10),
    .RST_VAL (sup_pkg::SYNC_RESET)
  ) u_sync (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .d       ({reset_button_n, ext_reset_in_n, handle_unlocked, handle_button, rails_ok,
               power_fault, sleep_state, disk_act_sata, disk_act_raid}),
    .q       ({btn_n_s, ext_n_s, unlocked_s, hbtn_s, rails_s,
               fault_s, sleep_s, sata_s, raid_s})
  );

  // ****************************************
  // Registers
  // ****************************************
  logic [5:0] ctrl_q;
  logic       trigger;
  logic [7:0] status;
  logic       armed_q;
  logic       soft_off_q;

  assign trigger = reg_req.wr && (reg_req.addr == sup_pkg::REG_CTRL);
  assign status  = {3'h0, fault_s, rails_s, unlocked_s, soft_off_q, armed_q};

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ctrl_q <= sup_pkg::CTRL_RESET;
    end else if (trigger) begin
      ctrl_q <= reg_req.wdata[5:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (reg_req.rd && reg_req.addr == sup_pkg::REG_CTRL) begin
      rdata <= {2'h0, ctrl_q};
    end else if (reg_req.rd && reg_req.addr == sup_pkg::REG_STATUS) begin
      rdata <= status;
    end else begin
      rdata <= 8'h00;
    end
  end

  // ****************************************
  // Watchdog
  // ****************************************
  function automatic logic [7:0] period_sec(input logic [1:0] sel);
    unique case (sel)
      2'h0:    period_sec = sup_pkg::PERIOD_SEC_0;
      2'h1:    period_sec = sup_pkg::PERIOD_SEC_1;
      2'h2:    period_sec = sup_pkg::PERIOD_SEC_2;
      2'h3:    period_sec = sup_pkg::PERIOD_SEC_3;
    endcase
  endfunction

  localparam int HW = $clog2(RST_HOLD_CYC + 1);

  logic          sec_tick;
  logic [7:0]    tmo_sec_q;
  logic          tmo_expire;
  logic [HW-1:0] tmo_hold_q;
  logic          btn_req;
  logic          ext_req;

  // Seconds restart on every trigger so the interval is measured exactly.
  tick_div #(
    .PERIOD  (SEC_CYCLES)
  ) u_tmo_sec (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .clr     (trigger || !armed_q),
    .tick    (sec_tick)
  );

  // Board reset clears the arm, so software cannot disarm by any write.
  always_ff @(posedge clk_sys) begin
    if (!rstn || !board_reset_n) begin
      armed_q <= 1'b0;
    end else if (trigger) begin
      armed_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn || !armed_q || trigger) begin
      tmo_sec_q <= 8'h00;
    end else if (sec_tick && !tmo_expire) begin
      tmo_sec_q <= tmo_sec_q + 8'h01;
    end
  end

  // The compare is greater-or-equal so a shortened period still expires.
  assign tmo_expire = armed_q && !trigger
                    && (tmo_sec_q >= period_sec(ctrl_q[1:0]));

  assign ext_req = !ext_n_s;
  assign btn_req = !btn_n_s && !ctrl_q[sup_pkg::CTRL_RSTDIS];

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      tmo_hold_q <= '0;
    end else if (tmo_expire) begin
      tmo_hold_q <= HW'(RST_HOLD_CYC - 1);
    end else if (tmo_hold_q != '0) begin
      tmo_hold_q <= tmo_hold_q - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      board_reset_n <= 1'b1;
    end else begin
      board_reset_n <= !(ext_req || btn_req || tmo_expire || tmo_hold_q != '0);
    end
  end

  // ****************************************
  // Front handle
  // ****************************************
  sup_pkg::handle_state_t hs_q;
  sup_pkg::handle_state_t hs_d;
  logic       hsec_tick;
  logic [2:0] hsec_q;
  logic [1:0] settle_q;
  logic       hbtn_prev_q;
  logic       pwr_dis;
  logic       ovr_now;

  assign pwr_dis = ctrl_q[sup_pkg::CTRL_PWRDIS];

  tick_div #(
    .PERIOD  (SEC_CYCLES)
  ) u_handle_sec (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .clr     (!unlocked_s),
    .tick    (hsec_tick)
  );

  always_ff @(posedge clk_sys) begin
    if (!rstn || !unlocked_s) begin
      hsec_q <= 3'h0;
    end else if (hsec_tick && hsec_q != sup_pkg::OVR_SEC) begin
      hsec_q <= hsec_q + 3'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      settle_q <= 2'h0;
    end else if (settle_q != 2'(sup_pkg::SETTLE_CYCLES)) begin
      settle_q <= settle_q + 2'h1;
    end
  end

  assign ovr_now = (hs_q == sup_pkg::HS_RUN) && unlocked_s && !pwr_dis
                 && (hsec_q == sup_pkg::OVR_SEC);

  always_comb begin
    hs_d = hs_q;
    unique case (hs_q)
      sup_pkg::HS_INIT: begin
        // The synchronisers must settle before the handle is judged.
        if (settle_q == 2'(sup_pkg::SETTLE_CYCLES)) begin
          hs_d = unlocked_s ? sup_pkg::HS_OFF_OPEN : sup_pkg::HS_RUN;
        end
      end
      sup_pkg::HS_RUN: begin
        if (ovr_now) begin
          hs_d = sup_pkg::HS_OFF_OPEN;
        end
      end
      sup_pkg::HS_OFF_OPEN: begin
        if (!unlocked_s) begin
          hs_d = sup_pkg::HS_OFF_LOCKED;
        end
      end
      sup_pkg::HS_OFF_LOCKED: begin
        if (unlocked_s) begin
          hs_d = sup_pkg::HS_OFF_REOPEN;
        end
      end
      sup_pkg::HS_OFF_REOPEN: begin
        if (!unlocked_s) begin
          hs_d = sup_pkg::HS_RUN;
        end
      end
      default: hs_d = sup_pkg::HS_INIT;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      hs_q       <= sup_pkg::HS_INIT;
      soft_off_q <= 1'b0;
    end else begin
      hs_q       <= hs_d;
      soft_off_q <= (hs_d != sup_pkg::HS_RUN) && (hs_d != sup_pkg::HS_INIT);
    end
  end

  assign soft_off = soft_off_q;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      hbtn_prev_q      <= 1'b0;
      pwr_btn_event    <= 1'b0;
      pwr_btn_override <= 1'b0;
    end else begin
      hbtn_prev_q      <= hbtn_s;
      pwr_btn_event    <= hbtn_s && !hbtn_prev_q && !pwr_dis;
      pwr_btn_override <= ovr_now;
    end
  end

  // ****************************************
  // Indicators
  // ****************************************
  logic blink_tick;
  logic blink_q;
  logic sleeping;
  logic s5;

  // One free-running divider drives every blinking lane, keeping them in phase.
  tick_div #(
    .PERIOD  (BLINK_CYCLES)
  ) u_blink (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .clr     (1'b0),
    .tick    (blink_tick)
  );

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      blink_q <= 1'b0;
    end else if (blink_tick) begin
      blink_q <= !blink_q;
    end
  end

  assign s5       = soft_off_q || (sleep_s == sup_pkg::SLP_S5);
  assign sleeping = s5 || (sleep_s != sup_pkg::SLP_S0);

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      power_good_indicator <= '0;
    end else if (fault_s) begin
      power_good_indicator <= '{red: 1'b1, green: 1'b0};
    end else if (unlocked_s) begin
      power_good_indicator <= '{red: blink_q, green: blink_q};
    end else if (ctrl_q[sup_pkg::CTRL_SWFAIL]) begin
      power_good_indicator <= '{red: blink_q, green: 1'b0};
    end else if (sleeping) begin
      power_good_indicator <= '0;
    end else begin
      power_good_indicator <= '{red: 1'b0,
                                green: rails_s && board_reset_n && hs_q == sup_pkg::HS_RUN};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      general_indicator       <= '0;
      disk_activity_indicator <= '0;
    end else if (s5) begin
      general_indicator       <= '{red: 1'b0, green: 1'b1};
      disk_activity_indicator <= '{red: 1'b0, green: 1'b1};
    end else if (sleep_s == sup_pkg::SLP_S4) begin
      general_indicator       <= '{red: 1'b0, green: 1'b1};
      disk_activity_indicator <= '0;
    end else if (sleep_s == sup_pkg::SLP_S3) begin
      general_indicator       <= '0;
      disk_activity_indicator <= '{red: 1'b0, green: 1'b1};
    end else begin
      general_indicator       <= '{red: 1'b0, green: ctrl_q[sup_pkg::CTRL_GPGREEN]};
      disk_activity_indicator <= '{red: raid_s, green: sata_s};
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_idle_no_expire: assert property (!armed_q && !trigger |=> !armed_q)
    else $error("watchdog expired while idle");
  a_arm_on_trig: assert property (trigger && board_reset_n |=> armed_q)
    else $error("trigger did not arm");
  a_expire_resets: assert property (tmo_expire |=> !board_reset_n [*2])
    else $error("expiry did not reset board");
  a_stay_armed: assert property (armed_q && board_reset_n |=> armed_q)
    else $error("watchdog disarmed without reset");
  a_period_write: assert property (trigger |=> ctrl_q[1:0] == $past(reg_req.wdata[1:0]))
    else $error("period not written");
  a_trig_restart: assert property (trigger |=> tmo_sec_q == 8'h00)
    else $error("trigger did not restart count");
  a_event_single: assert property (pwr_btn_event |=> !pwr_btn_event)
    else $error("event pulse too long");
  a_handle_dis: assert property (pwr_btn_event |-> !$past(pwr_dis))
    else $error("event while disabled");
  a_override_off: assert property (ovr_now |=> soft_off_q && pwr_btn_override)
    else $error("override did not reach soft-off");
  a_ext_reset: assert property (!ext_n_s |=> !board_reset_n)
    else $error("external reset ignored");
  a_fault_red: assert property (fault_s |=> power_good_indicator == 2'b10)
    else $error("fault not steady red");
  a_unlock_blink: assert property (!fault_s && unlocked_s |=>
    power_good_indicator.red == power_good_indicator.green)
    else $error("open handle not yellow");

  c_expiry: cover property (armed_q ##1 tmo_expire);
  c_override: cover property (pwr_btn_override);
  c_btn_event: cover property (pwr_btn_event);
  c_return_run: cover property (hs_q == sup_pkg::HS_OFF_REOPEN ##1 hs_q == sup_pkg::HS_RUN);

endmodule

// ---- pm_model.sv ----
module pm_model (
  input  wire logic       clk_sys,          // system clock
  input  wire logic       rstn,             // synchronous reset, active low
  input  wire logic [1:0] sleep_req,        // state the bench asks for
  input  wire logic       pwr_btn_event,    // event pulse from the board
  input  wire logic       pwr_btn_override, // override pulse from the board
  output logic      [1:0] sleep_state,      // state reported to the board
  output int              event_count,      // event pulses seen
  output int              override_count    // override pulses seen
);
  // ********
  // Chipset power state
  // ********
  // One cycle of lag stands in for the chipset's own response time.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sleep_state <= 2'h0;
    end else begin
      sleep_state <= sleep_req;
    end
  end

  // ********
  // Button pulse counters
  // ********
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      event_count    <= 0;
      override_count <= 0;
    end else begin
      event_count    <= event_count + int'(pwr_btn_event);
      override_count <= override_count + int'(pwr_btn_override);
    end
  end
endmodule

// ---- board_supervisor_watchdog_tb.sv ----
module board_supervisor_watchdog_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SEC  = 20;
  localparam int HOLD = 8;
  logic              clk_sys = 1'b0;
  logic              rstn    = 1'b0;
  sup_pkg::reg_req_t req     = '0;
  logic [7:0]        rdata;
  logic              btn_n = 1'b1, ext_n = 1'b1, hdl = 1'b0, hbtn = 1'b0;
  logic              rails = 1'b1, fault = 1'b0;
  logic [1:0]        sreq  = 2'h0, act = 2'h0, sleep;
  logic              brst_n, ev, ovr, soff;
  sup_pkg::led_t     pwr_lamp, gen_lamp, dsk_lamp;
  int                ev_cnt, ovr_cnt, n, err_count = 0, comparisons = 0, cycles = 0;
  int                secs[4] = '{2, 10, 50, 255};
  // Rows: sleep state, disk activity, then power, general and disk lamps.
  logic [9:0]        rows[5] = '{10'h010, 10'h0d3, 10'h101, 10'h204, 10'h305};

  always #10 clk_sys = ~clk_sys;

  board_supervisor_watchdog #(.SEC_CYCLES(SEC), .BLINK_CYCLES(4), .RST_HOLD_CYC(HOLD)) dut (
    .clk_sys(clk_sys), .rstn(rstn), .reg_req(req), .rdata(rdata),
    .reset_button_n(btn_n), .ext_reset_in_n(ext_n), .handle_unlocked(hdl),
    .handle_button(hbtn), .rails_ok(rails), .power_fault(fault), .sleep_state(sleep),
    .disk_act_sata(act[0]), .disk_act_raid(act[1]), .board_reset_n(brst_n),
    .pwr_btn_event(ev), .pwr_btn_override(ovr), .soft_off(soff),
    .power_good_indicator(pwr_lamp), .general_indicator(gen_lamp),
    .disk_activity_indicator(dsk_lamp));

  pm_model pm (.clk_sys(clk_sys), .rstn(rstn), .sleep_req(sreq), .pwr_btn_event(ev),
    .pwr_btn_override(ovr), .sleep_state(sleep), .event_count(ev_cnt),
    .override_count(ovr_cnt));

  // ********
  // Checking and bus tasks
  // ********
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    comparisons++;
    if (g < lo || g > hi) begin
      err_count++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask

  task automatic settle(input int k);
    cyc(k);
    #1;
  endtask

  task automatic rst_seq;
    @(posedge clk_sys);
    rstn <= 1'b0;
    cyc(8);
    rstn <= 1'b1;
    settle(8);
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    req <= '0;
  endtask

  task automatic reg_rd(input logic [3:0] a, input logic [7:0] e, input string nm);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    req <= '0;
    #1;
    chk(nm, e, rdata);
  endtask

  function automatic logic pick(input int w);
    return (w == 0) ? brst_n : soff;
  endfunction

  // Bounded wait on board reset (0) or soft-off (1); a hang shows as a count at the limit.
  task automatic wait_on(input int w, input logic v, input int lim, output int c);
    c = 0;
    while (pick(w) !== v && c < lim) begin
      settle(1);
      c++;
    end
  endtask

  // Over two blink periods the lamp must spend exactly half its time lit.
  task automatic blink(input string nm, input logic [1:0] on);
    int on_n;
    int off_n;
    on_n = 0;
    off_n = 0;
    repeat (16) begin
      settle(1);
      on_n += int'(pwr_lamp === on);
      off_n += int'(pwr_lamp === 2'h0);
    end
    chk_rng(nm, 8, 8, on_n);
    chk_rng(nm, 8, 8, off_n);
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  // ********
  // Sequence
  // ********
  initial begin
    rst_seq();
    foreach (rows[i]) begin
      cyc(1);
      sreq <= rows[i][9:8];
      act  <= rows[i][7:6];
      settle(6);
      chk("power lamp", 8'(rows[i][5:4]), 8'(pwr_lamp));
      chk("general lamp", 8'(rows[i][3:2]), 8'(gen_lamp));
      chk("disk lamp", 8'(rows[i][1:0]), 8'(dsk_lamp));
    end
    cyc(1);
    sreq  <= 2'h0;
    act   <= 2'h0;
    fault <= 1'b1;
    settle(6);
    chk("fault lamp", 8'h02, 8'(pwr_lamp));
    cyc(1);
    fault <= 1'b0;
    rails <= 1'b0;
    settle(6);
    chk("rails lamp", 8'h00, 8'(pwr_lamp));
    cyc(1);
    rails <= 1'b1;
    reg_wr(sup_pkg::REG_CTRL, 8'h07);
    cyc(4);
    blink("sw fail", 2'h2);
    reg_wr(sup_pkg::REG_CTRL, 8'h03);
    settle(6);
    chk("sw fail off", 8'h01, 8'(pwr_lamp));
    reg_wr(sup_pkg::REG_CTRL, 8'h23);
    reg_rd(sup_pkg::REG_CTRL, 8'h23, "ctrl readback");
    settle(4);
    chk("general green", 8'h01, 8'(gen_lamp));
    rst_seq();
    settle(200);
    chk("idle", 8'h01, 8'(brst_n));
    reg_rd(sup_pkg::REG_STATUS, 8'h08, "status");
    reg_rd(4'hc, 8'h00, "unmapped");
    reg_wr(sup_pkg::REG_CTRL, 8'h03);
    reg_rd(sup_pkg::REG_STATUS, 8'h09, "armed");
    repeat (4) begin
      cyc(30);
      reg_wr(sup_pkg::REG_CTRL, 8'h00);
    end
    reg_rd(sup_pkg::REG_STATUS, 8'h09, "still armed");
    chk("kept alive", 8'h01, 8'(brst_n));
    for (int p = 0; p < 4; p++) begin
      reg_wr(sup_pkg::REG_CTRL, 8'(p));
      wait_on(0, 1'b0, secs[p] * SEC + 10, n);
      chk_rng("expiry", secs[p] * SEC, secs[p] * SEC + 5, n);
      wait_on(0, 1'b1, HOLD + 10, n);
      chk_rng("hold", HOLD, HOLD + 3, n);
      reg_rd(sup_pkg::REG_STATUS, 8'h08, "disarmed");
    end
    cyc(1);
    ext_n <= 1'b0;
    wait_on(0, 1'b0, 8, n);
    chk_rng("ext reset", 2, 4, n);
    cyc(1);
    ext_n <= 1'b1;
    wait_on(0, 1'b1, 20, n);
    cyc(1);
    btn_n <= 1'b0;
    wait_on(0, 1'b0, 8, n);
    chk_rng("button reset", 2, 4, n);
    cyc(1);
    btn_n <= 1'b1;
    wait_on(0, 1'b1, 20, n);
    reg_wr(sup_pkg::REG_CTRL, 8'h0b);
    btn_n <= 1'b0;
    settle(10);
    chk("button ignored", 8'h01, 8'(brst_n));
    cyc(1);
    btn_n <= 1'b1;
    rst_seq();
    repeat (3) begin
      cyc(1);
      hbtn <= 1'b1;
      cyc(4);
      hbtn <= 1'b0;
      cyc(4);
    end
    settle(4);
    chk("events", 8'h03, 8'(ev_cnt));
    reg_wr(sup_pkg::REG_CTRL, 8'h13);
    hbtn <= 1'b1;
    cyc(4);
    hbtn <= 1'b0;
    settle(6);
    chk("events off", 8'h03, 8'(ev_cnt));
    reg_wr(sup_pkg::REG_CTRL, 8'h03);
    hdl <= 1'b1;
    cyc(4);
    blink("yellow", 2'h3);
    cyc(40);
    hdl <= 1'b0;
    settle(6);
    chk("short open", 8'h00, 8'(soff));
    cyc(1);
    hdl <= 1'b1;
    wait_on(1, 1'b1, 100, n);
    chk_rng("override", 80, 86, n);
    cyc(1);
    hdl <= 1'b0;
    settle(6);
    chk("override pulses", 8'h01, 8'(ovr_cnt));
    chk("off power lamp", 8'h00, 8'(pwr_lamp));
    chk("off general lamp", 8'h01, 8'(gen_lamp));
    chk("off disk lamp", 8'h01, 8'(dsk_lamp));
    cyc(1);
    hdl <= 1'b1;
    cyc(8);
    hdl <= 1'b0;
    settle(8);
    chk("resume", 8'h00, 8'(soff));
    chk("resume lamp", 8'h01, 8'(pwr_lamp));
    cyc(1);
    hdl <= 1'b1;
    rst_seq();
    chk("power-up open", 8'h01, 8'(soff));
    cyc(1);
    hdl <= 1'b0;
    cyc(8);
    hdl <= 1'b1;
    cyc(8);
    hdl <= 1'b0;
    settle(8);
    chk("interlock exit", 8'h00, 8'(soff));
    tally_and_finish();
  end
endmodule
